/* design/fpsf_top.sv */
`timescale 1ns/10ps
// Function
// - Frame overrun flag reads 1 once detected, stays until written 1.
// - With the enable set, data-phase start raises the wake interrupt.
// - Wake interrupt stays asserted until the start flag is cleared.
// - Every data-phase start sends a pulse to the delay block.
// - Start flag in bit 0 sets on each data-phase start.
// - Writing 1 to the start flag clears it.
// - Enabled frame start during run mode sets overrun flag, raises NMI.
// - Mode field: 00 off, 01 outside debug, 11 always, 10 reserved.
module fpsf_top
    import fpsf_pkg::*;
(
    input  wire logic        hclk,                  // System clock.
    input  wire logic        hresetn,               // Async reset, low.
    input  wire logic        hsel,                  // Slave select.
    input  wire logic [31:0] haddr,                 // Byte address.
    input  wire logic [1:0]  htrans,                // Transfer type.
    input  wire logic        hwrite,                // Write when high.
    input  wire logic [2:0]  hsize,                 // Transfer size.
    input  wire logic [31:0] hwdata,                // Write data.
    input  wire logic        hready,                // Bus ready.
    output logic      [31:0] hrdata,                // Read data.
    output logic             hreadyout,             // Slave ready.
    output logic             hresp,                 // Always OKAY.
    input  wire logic        frame_start,           // Frame start pulse.
    input  wire logic        data_phase_start,      // Data-phase start.
    input  wire logic        cpu_run_mode,          // CPU in run mode.
    input  wire logic        background_debug_enable, // Debug enabled.
    output logic             data_phase_start_pulse, // To delay block.
    output logic             wake_irq,              // CPU wake interrupt.
    output logic             nmi_level7,            // Level-7 interrupt.
    output logic             frame_overrun_flag,    // Overrun flag copy.
    output logic             data_phase_start_flag  // Start flag copy.
);

    typedef struct packed {
        logic [1:0]  err_mode;
        logic        irq_en;
        logic        wake_irq;
        logic        nmi;
        logic        dps_pulse;
        logic        ovr_copy;
        logic        start_copy;
        logic        wr_pend;
        logic        ready;
        logic [31:0] rdata;
    } fpsf_state_t;

    fpsf_state_t s;
    fpsf_state_t next_s;

    fpsf_flag_if ovr_if ();
    fpsf_flag_if start_if ();

    logic       addr_take;
    logic       addr_hit;
    logic       check_active;
    logic       err_set;
    logic       ovr_clear;
    logic       start_clear;
    logic [1:0] mode_now;

    fpsf_sticky_flag #(
        .RESET_VALUE (FPSF_FLAG_RESET)
    ) u_ovr_flag (
        .hclk    (hclk),
        .hresetn (hresetn),
        .port    (ovr_if)
    );

    fpsf_sticky_flag #(
        .RESET_VALUE (FPSF_FLAG_RESET)
    ) u_start_flag (
        .hclk    (hclk),
        .hresetn (hresetn),
        .port    (start_if)
    );

    assign addr_take = hsel && htrans[FPSF_HTRANS_ACTIVE] && hready;
    assign addr_hit  = (haddr & FPSF_ADDR_MASK) == FPSF_CSR_ADDR;

    // Writes land in the data phase, so the clear strobes use hwdata now.
    assign ovr_clear   = s.wr_pend && hwdata[FPSF_OVR_BIT];
    assign start_clear = s.wr_pend && hwdata[FPSF_START_BIT];

    // The checking mode in force is the stored one; a write takes effect
    // from the next cycle, which keeps the compare off the bus path.
    assign mode_now = s.err_mode;
    always_comb begin
        case (mode_now)
            FPSF_MODE_OFF:     check_active = 1'b0;
            FPSF_MODE_NODEBUG: check_active = !background_debug_enable;
            FPSF_MODE_ALWAYS:  check_active = 1'b1;
            FPSF_MODE_RSVD:    check_active = 1'b0;
            default:           check_active = 1'b0;
        endcase
    end

    assign err_set = frame_start && cpu_run_mode && check_active;

    assign ovr_if.set   = err_set;
    assign ovr_if.clr   = ovr_clear;
    assign start_if.set = data_phase_start;
    assign start_if.clr = start_clear;

    always_comb begin
        next_s           = s;
        next_s.ready     = 1'b1;
        next_s.dps_pulse = data_phase_start;
        next_s.nmi        = ovr_if.next_flag;
        next_s.ovr_copy   = ovr_if.next_flag;
        next_s.start_copy = start_if.next_flag;
        if (s.wr_pend) begin
            next_s.err_mode = hwdata[FPSF_MODE_MSB:FPSF_MODE_LSB];
            next_s.irq_en   = hwdata[FPSF_IRQ_EN_BIT];
        end
        // The interrupt latches at the start event and falls with the flag.
        next_s.wake_irq = (data_phase_start && s.irq_en)
                          || (s.wake_irq && start_if.next_flag);
        next_s.wr_pend  = addr_take && hwrite && addr_hit;
        // Read data come from the next state so a read right after a
        // write sees the written value.
        next_s.rdata = FPSF_RDATA_RESET;
        if (addr_take && !hwrite && addr_hit) begin
            next_s.rdata[FPSF_MODE_MSB:FPSF_MODE_LSB] = next_s.err_mode;
            next_s.rdata[FPSF_OVR_BIT]    = ovr_if.next_flag;
            next_s.rdata[FPSF_IRQ_EN_BIT] = next_s.irq_en;
            next_s.rdata[FPSF_START_BIT]  = start_if.next_flag;
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            s <= '{err_mode:  FPSF_MODE_RESET,
                   irq_en:    FPSF_IRQ_EN_RESET,
                   wake_irq:  1'b0,
                   nmi:       1'b0,
                   dps_pulse: 1'b0,
                   ovr_copy:  FPSF_FLAG_RESET,
                   start_copy: FPSF_FLAG_RESET,
                   wr_pend:   1'b0,
                   ready:     1'b1,
                   rdata:     FPSF_RDATA_RESET};
        end else begin
            s <= next_s;
        end
    end

    assign hrdata                 = s.rdata;
    assign hreadyout              = s.ready;
    assign hresp                  = 1'b0;
    assign data_phase_start_pulse = s.dps_pulse;
    assign wake_irq               = s.wake_irq;
    assign nmi_level7             = s.nmi;
    assign frame_overrun_flag     = s.ovr_copy;
    assign data_phase_start_flag  = s.start_copy;

    default clocking cb @(posedge hclk); endclocking
    default disable iff (!hresetn);

    sequence s_start_enabled;
        data_phase_start && s.irq_en;
    endsequence

    sequence s_clear_start;
        start_clear && !data_phase_start;
    endsequence

    AST_OVR_HOLD: assert property (
        frame_overrun_flag && !ovr_clear |=> frame_overrun_flag)
        else $error("Overrun flag dropped without a clearing write.");
    AST_IRQ_RISE: assert property (
        s_start_enabled |=> wake_irq && data_phase_start_flag)
        else $error("Wake interrupt missing after enabled start.");
    AST_IRQ_OFF: assert property (
        !wake_irq && !data_phase_start |=> !wake_irq)
        else $error("Wake interrupt rose without a start event.");
    AST_IRQ_DROP: assert property (
        wake_irq ##0 s_clear_start |=> !wake_irq && !data_phase_start_flag)
        else $error("Wake interrupt stayed after the flag was cleared.");
    AST_IRQ_STAY: assert property (
        wake_irq && !start_clear |=> wake_irq)
        else $error("Wake interrupt fell while the flag was set.");
    AST_PULSE: assert property (
        data_phase_start |=> data_phase_start_pulse ##1
        (data_phase_start_pulse == $past(data_phase_start)))
        else $error("Delay block pulse does not follow the start.");
    AST_OVR_SET: assert property (
        err_set |=> frame_overrun_flag && nmi_level7)
        else $error("Frame overrun not flagged or NMI missing.");
    AST_MODE_OFF: assert property (
        (s.err_mode == FPSF_MODE_OFF || s.err_mode == FPSF_MODE_RSVD)
        && !frame_overrun_flag && !ovr_clear |=> !frame_overrun_flag)
        else $error("Overrun flag set while checking was off.");
    AST_MODE_DBG: assert property (
        s.err_mode == FPSF_MODE_NODEBUG && background_debug_enable
        && !frame_overrun_flag |=> !frame_overrun_flag)
        else $error("Overrun flag set during debug in mode 01.");

    // A write that leaves a bit at zero must not touch the matching flag.
    sequence s_keep_start;
        data_phase_start_flag && s.wr_pend && !hwdata[FPSF_START_BIT];
    endsequence

    AST_START_KEEP: assert property (
        s_keep_start |=> data_phase_start_flag)
        else $error("Start flag dropped on a write of zero.");
    AST_SET_WINS: assert property (
        data_phase_start && start_clear |=> data_phase_start_flag)
        else $error("Clearing write beat a same-cycle start event.");
    AST_IRQ_MASKED: assert property (
        data_phase_start && !s.irq_en && !wake_irq |=> !wake_irq)
        else $error("Wake interrupt rose while it was disabled.");
    AST_PULSE_OFF: assert property (
        !data_phase_start |=> !data_phase_start_pulse)
        else $error("Delay block pulse without a start event.");
    AST_NMI_LEVEL: assert property (
        nmi_level7 == frame_overrun_flag)
        else $error("Level-7 interrupt does not follow the overrun flag.");
    AST_START_SET: assert property (
        data_phase_start |=> data_phase_start_flag)
        else $error("Start flag missing after a start event.");

endmodule

/* design/fpsf_pkg.sv */
package fpsf_pkg;

    // Register map of the frame control and status word.
    localparam logic [31:0] FPSF_CSR_ADDR      = 32'h0000_0000;
    localparam logic [31:0] FPSF_ADDR_MASK     = 32'h0000_00FC;

    // Bit positions inside the control and status word.
    localparam int          FPSF_START_BIT     = 0;
    localparam int          FPSF_IRQ_EN_BIT    = 1;
    localparam int          FPSF_OVR_BIT       = 2;
    localparam int          FPSF_MODE_LSB      = 3;
    localparam int          FPSF_MODE_MSB      = 4;

    // Values after reset.
    localparam logic [1:0]  FPSF_MODE_RESET    = 2'h0;
    localparam logic        FPSF_IRQ_EN_RESET  = 1'b0;
    localparam logic        FPSF_FLAG_RESET    = 1'b0;
    localparam logic [31:0] FPSF_RDATA_RESET   = 32'h0000_0000;

    // Encodings of the frame error checking mode field.
    localparam logic [1:0]  FPSF_MODE_OFF      = 2'h0;
    localparam logic [1:0]  FPSF_MODE_NODEBUG  = 2'h1;
    localparam logic [1:0]  FPSF_MODE_RSVD     = 2'h2;
    localparam logic [1:0]  FPSF_MODE_ALWAYS   = 2'h3;

    // AHB transfer type bit that marks NONSEQ or SEQ.
    localparam int          FPSF_HTRANS_ACTIVE = 1;

endpackage

/* design/fpsf_flag_if.sv */
`timescale 1ns/10ps
interface fpsf_flag_if;
    logic set;
    logic clr;
    logic flag;
    logic next_flag;

    modport owner (
        input  set,
        input  clr,
        output flag,
        output next_flag
    );
    modport user (
        output set,
        output clr,
        input  flag,
        input  next_flag
    );
endinterface

/* design/fpsf_sticky_flag.sv */
`timescale 1ns/10ps
module fpsf_sticky_flag
    import fpsf_pkg::*;
#(
    parameter logic RESET_VALUE = FPSF_FLAG_RESET
) (
    input  wire logic       hclk,    // System clock.
    input  wire logic       hresetn, // Asynchronous reset, active low.
    fpsf_flag_if.owner      port     // Set, clear and flag state.
);

    typedef struct packed {
        logic flag;
    } fpsf_sticky_t;

    fpsf_sticky_t s;
    fpsf_sticky_t next_s;

    // A set in the same cycle as a clearing write wins, so no event is lost.
    always_comb begin
        next_s = s;
        if (port.set) begin
            next_s.flag = 1'b1;
        end else if (port.clr) begin
            next_s.flag = 1'b0;
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            s <= '{flag: RESET_VALUE};
        end else begin
            s <= next_s;
        end
    end

    assign port.flag      = s.flag;
    assign port.next_flag = next_s.flag;

    default clocking cb @(posedge hclk); endclocking
    default disable iff (!hresetn);

    AST_FLAG_SET: assert property (port.set |=> port.flag)
        else $error("Sticky flag did not set after a set event.");
    AST_FLAG_CLR: assert property (port.clr && !port.set |=> !port.flag)
        else $error("Sticky flag did not clear after a clearing write.");
    AST_FLAG_KEEP: assert property ($rose(port.flag) |-> $past(port.set))
        else $error("Sticky flag rose without a set event.");
    AST_FLAG_HOLD: assert property (
        port.flag && !port.clr |=> port.flag)
        else $error("Sticky flag dropped without a clearing write.");

endmodule

/* bench/fpsf_event_src.sv */
`timescale 1ns/10ps
// Stands in for the frame timing source and the programmable delay block.
module fpsf_event_src (
    input  wire logic hclk,                    // System clock.
    input  wire logic pulse_in,                // Pulse from the block.
    output logic      frame_start,             // Frame start event.
    output logic      data_phase_start,        // Data-phase start event.
    output logic      cpu_run_mode,            // CPU run mode level.
    output logic      background_debug_enable, // Debug enable level.
    output int        n_pulse                  // Pulses seen by delay block.
);
    initial begin
        frame_start             = 1'b0;
        data_phase_start        = 1'b0;
        cpu_run_mode            = 1'b0;
        background_debug_enable = 1'b0;
        n_pulse                 = 0;
    end

    // Events are one-cycle pulses launched just after a rising edge.
    task automatic fire_dps();
        data_phase_start <= 1'b1;
        @(posedge hclk);
        data_phase_start <= 1'b0;
    endtask

    task automatic fire_fs(input logic run, input logic dbg);
        cpu_run_mode            <= run;
        background_debug_enable <= dbg;
        frame_start             <= 1'b1;
        @(posedge hclk);
        frame_start             <= 1'b0;
    endtask

    // Counting high cycles also catches a pulse that stretches too long.
    always @(posedge hclk) begin
        if (pulse_in === 1'b1) begin
            n_pulse <= n_pulse + 1;
        end
    end
endmodule

/* bench/fpsf_top_tb_top.sv */
`timescale 1ns/10ps
module fpsf_top_tb_top
    import fpsf_pkg::*;
;
    logic        hclk, hresetn, hsel, hwrite, rd_dp;
    logic [31:0] haddr, hwdata;
    logic [1:0]  htrans, m_mode;
    logic [2:0]  hsize;
    logic [35:0] expq[$];
    logic [35:0] exp_v;
    logic        m_start, m_ovr, m_en, m_wake;
    wire logic [31:0] hrdata;
    wire logic   hreadyout, hresp, pulse, wake_irq, nmi, ovr_o, start_o;
    wire logic   fstart, dstart, run, dbg;
    int          n_pulse, exp_pulse, n_mismatch, samples_checked, cycles;
    int          i;

    fpsf_top dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
        .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
        .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
        .hreadyout(hreadyout), .hresp(hresp), .frame_start(fstart),
        .data_phase_start(dstart), .cpu_run_mode(run),
        .background_debug_enable(dbg), .data_phase_start_pulse(pulse),
        .wake_irq(wake_irq), .nmi_level7(nmi), .frame_overrun_flag(ovr_o),
        .data_phase_start_flag(start_o));

    fpsf_event_src src (.hclk(hclk), .pulse_in(pulse), .frame_start(fstart),
        .data_phase_start(dstart), .cpu_run_mode(run),
        .background_debug_enable(dbg), .n_pulse(n_pulse));

    initial begin
        hclk = 1'b0;
        forever #10 hclk = ~hclk;
    end

    task automatic stop_test();
        $display("checked %0d mismatches %0d", samples_checked, n_mismatch);
        if (n_mismatch == 0 && samples_checked > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask

    // Entered just after a rising edge; returns at the data-phase edge.
    task automatic bus(input logic [31:0] a, input logic w,
                       input logic [31:0] d, input logic coll);
        hsel   <= 1'b1;
        haddr  <= a;
        hwrite <= w;
        htrans <= 2'h2;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        htrans <= 2'h0;
        hwdata <= d;
        if (coll) fork src.fire_dps(); join_none
        do @(posedge hclk); while (hreadyout !== 1'b1);
    endtask

    task automatic chk(input logic [31:0] a);
        logic [31:0] v;
        v = (a == FPSF_CSR_ADDR) ? {27'h0, m_mode, m_ovr, m_en, m_start} : '0;
        expq.push_back({m_wake, m_ovr, m_ovr, m_start, v});
        bus(a, 1'b0, 32'h0000_0000, 1'b0);
    endtask

    // Upper data bits are random; they must read back as zero.
    task automatic wr(input logic [31:0] a, input logic [4:0] lo,
                      input logic coll);
        logic [31:0] d;
        d = ($urandom() & 32'hFFFF_FFE0) | {27'h0, lo};
        bus(a, 1'b1, d, coll);
        if (a == FPSF_CSR_ADDR) begin
            m_en   = lo[1];
            m_mode = lo[4:3];
            if (lo[0]) {m_start, m_wake} = 2'b00;
            if (lo[2]) m_ovr = 1'b0;
        end
        if (coll) begin
            m_start = 1'b1;
            m_wake = m_wake | m_en;
            exp_pulse++;
        end
    endtask

    task automatic dps();
        src.fire_dps();
        m_start = 1'b1;
        m_wake = m_wake | m_en;
        exp_pulse++;
    endtask

    task automatic fs(input logic r, input logic g);
        src.fire_fs(r, g);
        if (r && (m_mode == FPSF_MODE_ALWAYS ||
                  (m_mode == FPSF_MODE_NODEBUG && !g))) m_ovr = 1'b1;
    endtask

    always @(posedge hclk) begin
        if (rd_dp) begin
            exp_v = expq.pop_front();
            samples_checked++;
            if ({hresp, wake_irq, nmi, ovr_o, start_o, hrdata} !==
                {1'b0, exp_v}) begin
                n_mismatch++;
                $display("ERROR %0t read got %h want %h", $time,
                         {wake_irq, nmi, ovr_o, start_o, hrdata}, exp_v);
            end
        end
        rd_dp <= hsel && htrans[1] && !hwrite && hreadyout;
    end

    always @(posedge hclk) begin
        cycles++;
        if (cycles == 20000) begin
            n_mismatch++;
            stop_test();
        end
    end

    initial begin
        {hsel, hwrite, hresetn} = 3'h0;
        {haddr, hwdata, htrans} = '0;
        hsize = 3'h2;
        {m_start, m_ovr, m_en, m_wake, m_mode} = '0;
        void'($urandom(32'h68bf7c19));
        repeat (20) @(posedge hclk);
        hresetn <= 1'b1;
        @(posedge hclk);
        chk(FPSF_CSR_ADDR);
        dps();
        chk(FPSF_CSR_ADDR);
        wr(FPSF_CSR_ADDR, 5'h00, 1'b0);
        chk(FPSF_CSR_ADDR);
        wr(FPSF_CSR_ADDR, 5'h01, 1'b0);
        chk(FPSF_CSR_ADDR);
        wr(FPSF_CSR_ADDR, 5'h02, 1'b0);
        dps();
        chk(FPSF_CSR_ADDR);
        wr(FPSF_CSR_ADDR, 5'h00, 1'b0);
        chk(FPSF_CSR_ADDR);
        wr(FPSF_CSR_ADDR, 5'h01, 1'b0);
        chk(FPSF_CSR_ADDR);
        wr(FPSF_CSR_ADDR, 5'h02, 1'b0);
        dps();
        wr(FPSF_CSR_ADDR, 5'h03, 1'b1);
        chk(FPSF_CSR_ADDR);
        wr(32'h0000_0010, 5'h1F, 1'b0);
        chk(32'h0000_0010);
        chk(FPSF_CSR_ADDR);
        for (i = 0; i < 16; i++) begin
            wr(FPSF_CSR_ADDR, {i[3:2], 3'b100}, 1'b0);
            fs(i[1], i[0]);
            chk(FPSF_CSR_ADDR);
        end
        repeat (3) @(posedge hclk);
        samples_checked++;
        if (n_pulse != exp_pulse) begin
            n_mismatch++;
            $display("ERROR %0t pulse count %0d", $time, n_pulse);
        end
        stop_test();
    end
endmodule
